// ===== inc/psrp_pkg.sv
// Shared constants and types for the serial register port
package psrp_pkg;

  // ----------------------------------------------------------------
  // Slave addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] PSRP_CTL_ADDR = 7'h2D;
  localparam logic [6:0] PSRP_SCL_ADDR = 7'h12;

  // ----------------------------------------------------------------
  // Core converter voltage scaling register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] PSRP_IDX_CORE1_OP = 8'h20;
  localparam logic [7:0] PSRP_IDX_CORE1_SR = 8'h21;
  localparam logic [7:0] PSRP_IDX_CORE2_OP = 8'h22;
  localparam logic [7:0] PSRP_IDX_CORE2_SR = 8'h23;

  // ----------------------------------------------------------------
  // Field layout, reset values, buffer shape
  // ----------------------------------------------------------------
  localparam int PSRP_BYTE_W = 8;
  localparam int PSRP_WR_W = 16;
  localparam int PSRP_FIFO_DEPTH = 4;
  localparam logic [3:0] PSRP_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PSRP_LAST_BIT = 4'h7;
  localparam logic [2:0] PSRP_SYNC_RST = 3'h7;
  localparam logic [7:0] PSRP_DENIED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Timing: bus rates and the local clock
  // ----------------------------------------------------------------
  localparam int PSRP_CLK_HZ = 50000000;
  localparam int PSRP_STD_BPS = 100000;
  localparam int PSRP_FAST_BPS = 400000;
  localparam int PSRP_HS_BPS = 3400000;
  // Local clocks per bit at the fastest rate, rounded down
  localparam int PSRP_HS_BIT_CYC = PSRP_CLK_HZ / PSRP_HS_BPS;

  // ----------------------------------------------------------------
  // Per-port byte engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSRP_IDLE,
    PSRP_ADDR,
    PSRP_ACK,
    PSRP_WRITE,
    PSRP_PUSH,
    PSRP_READ,
    PSRP_RACK
  } psrp_state_e;

endpackage : psrp_pkg

// ===== hdl/psrp_fifo.sv
// Small register FIFO with valid and ready on both sides
`timescale 1ns/1ps
module psrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign do_push = in_valid_i & in_ready_o;
  assign do_pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  // Storage, no reset needed on the data words
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap at DEPTH so any depth works
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : psrp_fifo

// ===== hdl/psrp_port.sv
// Two-wire slave register ports: general control and voltage scaling
//
// How it works
// - Pins filtered at 50 MHz serve standard, fast and high-speed bit rates.
// - Control port answers only fixed 7-bit address 2Dh.
// - Scaling port answers only fixed 7-bit address 12h.
// - Both ports are slaves only; they never start transfers or drive clock high.
// - Ten-bit headers and general call never match, so they are ignored.
// - Write: address byte, register index byte, then data stored at index.
// - Read: index written, repeated start with read, register returned as fourth byte.
// - Each written data byte goes to current index, index then advances one.
// - Reads keep returning consecutive registers while master acknowledges.
// - Scaling port lives only in alternate pin mode; else pins are plain enables.
// - Control port reaches every 8-bit device register other than the scaling registers.
// - Scaling port reaches only core converter operating and slew registers.
// - Control port reaches scaling registers only while select bit is one.
`timescale 1ns/1ps
module psrp_port
  import psrp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ctl_scl_i,
  output logic ctl_scl_o,
  output logic ctl_scl_oe_o,
  input wire logic ctl_sda_i,
  output logic ctl_sda_o,
  output logic ctl_sda_oe_o,
  input wire logic enable_pin_one_i,
  output logic enable_pin_one_o,
  output logic enable_pin_one_oe_o,
  input wire logic enable_pin_two_i,
  output logic enable_pin_two_o,
  output logic enable_pin_two_oe_o,
  input wire logic scaling_port_enable_i,
  input wire logic scaling_access_select_i,
  output logic enable_one_level_o,
  output logic enable_two_level_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [7:0] wr_index_o,
  output logic [7:0] wr_data_o,
  output logic [1:0][7:0] rd_index_o,
  input wire logic [1:0][7:0] rd_data_i
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Pin gathering
  // ----------------------------------------------------------------
  logic [1:0] scl_pin;
  logic [1:0] sda_pin;
  logic [1:0] scl_line;
  logic [1:0] scl_hold;
  logic [1:0] sda_drive;
  logic [1:0] want;
  logic [1:0] gnt;
  logic [1:0][PSRP_WR_W-1:0] pdata;
  logic fifo_in_ready;

  assign scl_pin = {enable_pin_one_i, ctl_scl_i};
  assign sda_pin = {enable_pin_two_i, ctl_sda_i};

  // Open drain: only ever pull low, and the clock only for stretching
  assign ctl_scl_o = 1'b0;
  assign ctl_sda_o = 1'b0;
  assign enable_pin_one_o = 1'b0;
  assign enable_pin_two_o = 1'b0;
  assign ctl_scl_oe_o = scl_hold[0];
  assign ctl_sda_oe_o = sda_drive[0];
  assign enable_pin_one_oe_o = scl_hold[1];
  assign enable_pin_two_oe_o = sda_drive[1];

  // Fixed priority: control port first, the loser keeps stretching
  assign gnt[0] = want[0];
  assign gnt[1] = want[1] & ~want[0];

  // ----------------------------------------------------------------
  // Byte engines, one per port
  // ----------------------------------------------------------------
  genvar p;
  for (p = 0; p < 2; p++) begin : g_port
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    psrp_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] idx;
    logic have_idx;
    logic rnw;
    logic live;
    logic is_scaling;
    logic allowed;
    logic [7:0] rd_val;
    logic [6:0] my_addr;

    // Three-stage sampling; a level counts once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        scl_s <= PSRP_SYNC_RST;
        sda_s <= PSRP_SYNC_RST;
        scl_f <= 1'b1;
        sda_f <= 1'b1;
        scl_q <= 1'b1;
        sda_q <= 1'b1;
      end else begin
        scl_s <= {scl_s[1:0], scl_pin[p]};
        sda_s <= {sda_s[1:0], sda_pin[p]};
        if (scl_s[1] == scl_s[2]) begin
          scl_f <= scl_s[2];
        end
        if (sda_s[1] == sda_s[2]) begin
          sda_f <= sda_s[2];
        end
        scl_q <= scl_f;
        sda_q <= sda_f;
      end
    end

    // Bus conditions seen on the filtered lines
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start_c = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_c = scl_f & scl_q & ~sda_q & sda_f;

    // Address, reach and read data selection
    assign my_addr = (p == 0) ? PSRP_CTL_ADDR : PSRP_SCL_ADDR;
    assign live = (p == 0) | scaling_port_enable_i;
    assign is_scaling = (idx == PSRP_IDX_CORE1_OP) | (idx == PSRP_IDX_CORE1_SR) |
                        (idx == PSRP_IDX_CORE2_OP) | (idx == PSRP_IDX_CORE2_SR);
    // Control port sees everything except scaling registers unless selected
    assign allowed = is_scaling ? ((p == 1) | scaling_access_select_i) : (p == 0);
    assign rd_val = allowed ? rd_data_i[p] : PSRP_DENIED_READ;
    assign rd_index_o[p] = idx;
    assign want[p] = (st == PSRP_PUSH);
    assign pdata[p] = {idx, sh};
    assign scl_line[p] = scl_f;

    // Protocol sequencing; start and stop override any state
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        st <= PSRP_IDLE;
        bitcnt <= 4'h0;
        sh <= 8'h00;
        idx <= 8'h00;
        have_idx <= 1'b0;
        rnw <= 1'b0;
        sda_drive[p] <= 1'b0;
        scl_hold[p] <= 1'b0;
      end else if (!live) begin
        st <= PSRP_IDLE;
        sda_drive[p] <= 1'b0;
        scl_hold[p] <= 1'b0;
      end else if (start_c) begin
        // Repeated start keeps the index for the read that follows
        st <= PSRP_ADDR;
        bitcnt <= 4'h0;
        have_idx <= 1'b0;
        sda_drive[p] <= 1'b0;
        scl_hold[p] <= 1'b0;
      end else if (stop_c) begin
        st <= PSRP_IDLE;
        sda_drive[p] <= 1'b0;
        scl_hold[p] <= 1'b0;
      end else begin
        case (st)
          PSRP_ADDR, PSRP_WRITE: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_f};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == PSRP_BITS_PER_BYTE) begin
              if (st == PSRP_ADDR) begin
                // 10-bit headers and address 00h never equal our address
                if (sh[7:1] == my_addr) begin
                  rnw <= sh[0];
                  sda_drive[p] <= 1'b1;
                  st <= PSRP_ACK;
                end else begin
                  st <= PSRP_IDLE;
                end
              end else if (!have_idx) begin
                idx <= sh;
                have_idx <= 1'b1;
                sda_drive[p] <= 1'b1;
                st <= PSRP_ACK;
              end else if (allowed) begin
                // Hold the clock low until the buffer takes the byte
                scl_hold[p] <= 1'b1;
                st <= PSRP_PUSH;
              end else begin
                idx <= idx + 8'h01;
                sda_drive[p] <= 1'b1;
                st <= PSRP_ACK;
              end
            end
          end
          PSRP_PUSH: begin
            if (gnt[p] && fifo_in_ready) begin
              // Ack goes low first; the clock is let go one cycle later so data never moves with it high
              idx <= idx + 8'h01;
              sda_drive[p] <= 1'b1;
              st <= PSRP_ACK;
            end
          end
          PSRP_ACK: begin
            scl_hold[p] <= 1'b0;
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rnw) begin
                sh <= rd_val;
                sda_drive[p] <= ~rd_val[7];
                st <= PSRP_READ;
              end else begin
                sda_drive[p] <= 1'b0;
                st <= PSRP_WRITE;
              end
            end
          end
          PSRP_READ: begin
            if (scl_fall) begin
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == PSRP_LAST_BIT) begin
                sda_drive[p] <= 1'b0;
                st <= PSRP_RACK;
              end else begin
                sh <= {sh[6:0], 1'b0};
                sda_drive[p] <= ~sh[6];
              end
            end
          end
          PSRP_RACK: begin
            if (scl_rise) begin
              if (sda_f) begin
                st <= PSRP_IDLE;
              end else begin
                idx <= idx + 8'h01;
                st <= PSRP_ACK;
              end
            end
          end
          default: begin
            st <= PSRP_IDLE;
            sda_drive[p] <= 1'b0;
            scl_hold[p] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Plain enable levels when the scaling port is off
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enable_one_level_o <= 1'b0;
      enable_two_level_o <= 1'b0;
    end else begin
      enable_one_level_o <= ~scaling_port_enable_i & scl_line[1];
      enable_two_level_o <= ~scaling_port_enable_i & g_port[1].sda_f;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer toward the register file
  // ----------------------------------------------------------------
  psrp_fifo #(
    .WIDTH(PSRP_WR_W),
    .DEPTH(PSRP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(|want),
    .in_ready_o(fifo_in_ready),
    .in_data_i(gnt[0] ? pdata[0] : pdata[1]),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o({wr_index_o, wr_data_o})
  );

endmodule : psrp_port

// ===== verif/psrp_port_asserts.sv
// Checker on the serial register port pins and write buffer
`timescale 1ns/1ps
module psrp_port_asserts
  import psrp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ctl_scl_i,
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oe_o,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe_o,
  input wire logic enable_pin_one_i,
  input wire logic enable_pin_one_o,
  input wire logic enable_pin_one_oe_o,
  input wire logic enable_pin_two_o,
  input wire logic enable_pin_two_oe_o,
  input wire logic scaling_port_enable_i,
  input wire logic enable_one_level_o,
  input wire logic enable_two_level_o,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [7:0] wr_index_o,
  input wire logic [7:0] wr_data_o,
  input wire logic [1:0][7:0] rd_index_o
);
  // Cycles since reset, so the pin filter has settled before we judge it
  logic [3:0] up_cnt;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      up_cnt <= 4'h0;
    end else if (up_cnt != 4'hF) begin
      up_cnt <= up_cnt + 4'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_off; !scaling_port_enable_i [*3]; endsequence
  sequence s_stall; wr_valid_o && !wr_ready_i; endsequence
  sequence s_quiet; !scaling_port_enable_i && $stable(enable_pin_one_i); endsequence
  // Open drain: only pulls low, never drives high
  open_drain_a: assert property (!(ctl_scl_o || ctl_sda_o || enable_pin_one_o || enable_pin_two_o))
    else $error("pin value driven high");
  stretch_low_a: assert property ($rose(ctl_scl_oe_o) |-> !ctl_scl_i)
    else $error("clock pulled while high");
  ctl_data_low_a: assert property ($changed(ctl_sda_oe_o) |-> !ctl_scl_i)
    else $error("control data moved with clock high");
  scl_data_low_a: assert property ($changed(enable_pin_two_oe_o) |-> !enable_pin_one_i)
    else $error("scaling data moved with clock high");
  scaling_dead_a: assert property (s_off |-> !enable_pin_one_oe_o && !enable_pin_two_oe_o)
    else $error("scaling pins pulled while off");
  scale_index_a: assert property (s_off |-> $stable(rd_index_o[1]))
    else $error("scaling index moved while off");
  level_mask_a: assert property (scaling_port_enable_i [*2] |-> !enable_one_level_o && !enable_two_level_o)
    else $error("enable level shown in port mode");
  level_follow_a: assert property (up_cnt == 4'hF ##0 s_quiet [*8] |-> enable_one_level_o == enable_pin_one_i)
    else $error("enable level does not follow pin");
  wr_hold_a: assert property (s_stall |=> wr_valid_o && $stable(wr_index_o) && $stable(wr_data_o))
    else $error("write entry lost before taken");
endmodule : psrp_port_asserts

bind psrp_port psrp_port_asserts u_psrp_port_asserts (.*);

// ===== verif/psrp_host_model.sv
// Two-wire bus master model driving one slave port
`timescale 1ns/1ps
module psrp_host_model #(
  parameter int LOW_CYC = 12,
  parameter int HIGH_CYC = 4
) (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  // Low phase widened past the slave's answer latency; high phase short
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // One clock pulse; a stretching slave holds us in the low phase
  task automatic pulse(output logic smp);
    int guard;
    guard = 0;
    scl_pull_o = 1'b0;
    while (scl_i !== 1'b1 && guard < 400) begin
      tick(1);
      guard++;
    end
    tick(HIGH_CYC);
    smp = sda_i;
    scl_pull_o = 1'b1;
    tick(2);
  endtask : pulse
  task automatic start();
    sda_pull_o = 1'b0;
    tick(LOW_CYC);
    scl_pull_o = 1'b0;
    tick(HIGH_CYC);
    sda_pull_o = 1'b1;
    tick(HIGH_CYC);
    scl_pull_o = 1'b1;
    tick(2);
  endtask : start
  task automatic stop();
    sda_pull_o = 1'b1;
    tick(LOW_CYC);
    scl_pull_o = 1'b0;
    tick(HIGH_CYC);
    sda_pull_o = 1'b0;
    tick(LOW_CYC);
  endtask : stop
  // Byte out MSB first, then the ninth bit; 7-bit headers only
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_pull_o = ~tx[i];
      tick(LOW_CYC - 2);
      pulse(b);
      rx[i] = b;
    end
    sda_pull_o = ~ai;
    tick(LOW_CYC - 2);
    pulse(b);
    ack = ~b;
  endtask : xfer
  // Plain levels for the enable-pin mode
  task automatic hold(input logic c, input logic d);
    scl_pull_o = ~c;
    sda_pull_o = ~d;
    tick(12);
  endtask : hold
endmodule : psrp_host_model

// ===== verif/psrp_port_tb.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module psrp_port_tb;
  import psrp_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  wire [1:0] scl_pull, sda_pull, scl_oe, sda_oe, scl_o, sda_o, scl_w, sda_w;
  logic port_en = 1'b1;
  logic sel = 1'b0;
  logic lv1, lv2, wr_valid;
  logic wr_ready = 1'b0;
  logic [7:0] wr_index, wr_data, b;
  wire [1:0][7:0] rd_index, rd_data;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  logic [6:0] bad [4];
  integer seed = 32'hc508;
  int errors = 0;
  int cmp_count = 0;
  int n;
  always #10 clk_i = ~clk_i;
  // Open-drain wires with pull-up
  assign scl_w = ~(scl_pull | scl_oe);
  assign sda_w = ~(sda_pull | sda_oe);
  assign rd_data[0] = mem[rd_index[0]];
  assign rd_data[1] = mem[rd_index[1]];
  psrp_port u_psrp_port (.clk_i(clk_i), .rstn_i(rstn_i),
    .ctl_scl_i(scl_w[0]), .ctl_scl_o(scl_o[0]), .ctl_scl_oe_o(scl_oe[0]),
    .ctl_sda_i(sda_w[0]), .ctl_sda_o(sda_o[0]), .ctl_sda_oe_o(sda_oe[0]),
    .enable_pin_one_i(scl_w[1]), .enable_pin_one_o(scl_o[1]), .enable_pin_one_oe_o(scl_oe[1]),
    .enable_pin_two_i(sda_w[1]), .enable_pin_two_o(sda_o[1]), .enable_pin_two_oe_o(sda_oe[1]),
    .scaling_port_enable_i(port_en), .scaling_access_select_i(sel),
    .enable_one_level_o(lv1), .enable_two_level_o(lv2), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .wr_index_o(wr_index), .wr_data_o(wr_data), .rd_index_o(rd_index), .rd_data_i(rd_data));
  psrp_host_model u_host_ctl (.clk_i(clk_i), .scl_i(scl_w[0]), .sda_i(sda_w[0]),
    .scl_pull_o(scl_pull[0]), .sda_pull_o(sda_pull[0]));
  psrp_host_model u_host_scl (.clk_i(clk_i), .scl_i(scl_w[1]), .sda_i(sda_w[1]),
    .scl_pull_o(scl_pull[1]), .sda_pull_o(sda_pull[1]));
  // Register file stand-in; random stalls delay taking entries from the write buffer
  always @(posedge clk_i) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) mem[wr_index] <= wr_data;
    #1 wr_ready = ($random(seed) % 3) != 0;
  end
  function automatic logic ok_idx(input bit p, input logic [7:0] idx);
    logic core;
    core = idx >= PSRP_IDX_CORE1_OP && idx <= PSRP_IDX_CORE2_SR;
    return p ? core : (sel || !core);
  endfunction : ok_idx
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic xb(input bit p, input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ack);
    if (p) u_host_scl.xfer(tx, ai, rx, ack);
    else u_host_ctl.xfer(tx, ai, rx, ack);
  endtask : xb
  task automatic bus(input bit p, input bit go);
    if (p) begin
      if (go) u_host_scl.start(); else u_host_scl.stop();
    end else begin
      if (go) u_host_ctl.start(); else u_host_ctl.stop();
    end
  endtask : bus
  task automatic wr_txn(input bit p, input logic [6:0] a, input logic [7:0] idx, input int n, input logic live);
    logic [7:0] rx, d;
    logic ack;
    bus(p, 1);
    xb(p, {a, 1'b0}, 1'b1, rx, ack);
    check("address ack", {7'h0, ack}, {7'h0, live});
    if (ack === 1'b1) begin
      xb(p, idx, 1'b1, rx, ack);
      check("index ack", {7'h0, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
        d = $random(seed);
        xb(p, d, 1'b1, rx, ack);
        check("data ack", {7'h0, ack}, 8'h01);
        if (ok_idx(p, idx)) exp_mem[idx] = d;
        idx++;
      end
    end
    bus(p, 0);
  endtask : wr_txn
  task automatic rd_txn(input bit p, input logic [6:0] a, input logic [7:0] idx, input int n);
    logic [7:0] rx;
    logic ack;
    for (int g = 0; g < 200 && wr_valid !== 1'b0; g++) @(posedge clk_i);
    bus(p, 1);
    xb(p, {a, 1'b0}, 1'b1, rx, ack);
    xb(p, idx, 1'b1, rx, ack);
    bus(p, 1);
    xb(p, {a, 1'b1}, 1'b1, rx, ack);
    check("read address ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      xb(p, 8'hFF, i == n - 1, rx, ack);
      check("read data", rx, ok_idx(p, idx) ? exp_mem[idx] : PSRP_DENIED_READ);
      idx++;
    end
    bus(p, 0);
  endtask : rd_txn
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    #1800000;
    errors++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = $random(seed);
      exp_mem[i] = mem[i];
    end
    repeat (5) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (8) @(posedge clk_i);
    check("level in port mode", {6'h0, lv1, lv2}, 8'h00);
    // Random bursts with readback, then index wrap and core window
    for (int t = 0; t < 4; t++) begin
      b = $random(seed);
      n = 1 + {$random(seed)} % 6;
      wr_txn(0, PSRP_CTL_ADDR, b, n, 1'b1);
      rd_txn(0, PSRP_CTL_ADDR, b, n);
    end
    wr_txn(0, PSRP_CTL_ADDR, 8'hFE, 3, 1'b1);
    rd_txn(0, PSRP_CTL_ADDR, 8'hFE, 3);
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      wr_txn(0, PSRP_CTL_ADDR, 8'h1F, 6, 1'b1);
      rd_txn(0, PSRP_CTL_ADDR, 8'h1F, 6);
      wr_txn(1, PSRP_SCL_ADDR, 8'h1F, 6, 1'b1);
      rd_txn(1, PSRP_SCL_ADDR, 8'h1E, 7);
    end
    // Foreign addresses, general call and ten-bit header 78h go unanswered
    // Random foreign address kept in 40h..7Fh so it can hit neither port
    bad = '{7'h00, 7'h78, 7'h7B, 7'h40 | 7'($random(seed))};
    for (int k = 0; k < 4; k++) begin
      wr_txn(0, (k == 2) ? PSRP_SCL_ADDR : bad[k], 8'h10, 1, 1'b0);
      wr_txn(1, (k == 2) ? PSRP_CTL_ADDR : bad[k], 8'h20, 1, 1'b0);
    end
    // Pins become plain enables when the scaling port is off
    port_en = 1'b0;
    wr_txn(1, PSRP_SCL_ADDR, PSRP_IDX_CORE1_OP, 1, 1'b0);
    for (int c = 0; c < 4; c++) begin
      u_host_scl.hold(c[1], c[0]);
      check("enable levels", {6'h0, lv1, lv2}, 8'(c));
    end
    u_host_scl.hold(1'b1, 1'b1);
    port_en = 1'b1;
    rd_txn(1, PSRP_SCL_ADDR, PSRP_IDX_CORE1_OP, 4);
    tally_and_finish();
  end
endmodule : psrp_port_tb
